// >>> design/fspmc_ctrl.sv
// flash self-program mode control register
// assumes byte-wide cpu writes and reads synchronous to core_clk
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - register written only as whole byte
// - reset loads register to 08h
// - voltage flag read-only, reflects programming pin
// - select bit: 0 normal, 1 self-program
module fspmc_ctrl
#(
    parameter int unsigned DATA_W = fspmc_pkg::FSPMC_DATA_W
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic [7:0] cpu_byte_en,
    input wire logic [DATA_W-1:0] cpu_wdata,
    output logic [DATA_W-1:0] cpu_rdata,
    input wire logic prog_voltage_present,
    output logic self_program_select
);
    import fspmc_pkg::*;

    // one byte register: the select bit is written state, the
    // voltage bit mirrors the detector pin; readback and select
    // are registered, so a write shows one edge after it is taken
    // and the flag lags the pin by one edge; writes that are not
    // whole-byte, or go to another address, are dropped silently

    // ==============================================
    // elaboration checks
    // the field layout is built for one byte; any other
    // width would misplace the flag bits
    if (DATA_W != FSPMC_DATA_W)
    begin : g_bad_data_w
        $error("fspmc_ctrl serves an eight-bit data bus only");
    end

    // both fields must sit inside the data word
    if (FSPMC_SELECT_BIT >= DATA_W || FSPMC_VOLTAGE_BIT >= DATA_W)
    begin : g_bad_field
        $error("fspmc_ctrl field position outside the word");
    end

    // select and voltage flag may not share a bit
    if (FSPMC_SELECT_BIT == FSPMC_VOLTAGE_BIT)
    begin : g_field_clash
        $error("fspmc_ctrl select and voltage fields overlap");
    end

    // the read-only flag must stay out of the write mask
    if (FSPMC_WRITE_MASK[FSPMC_VOLTAGE_BIT])
    begin : g_flag_writable
        $error("fspmc_ctrl voltage flag in the write mask");
    end

    // ==============================================
    // helpers
    // whole-byte access: every byte lane enabled
    function automatic logic lanes_full(input logic [7:0] lanes);
        return lanes == 8'hff;
    endfunction

    // readback word: select and voltage flag, others zero
    function automatic logic [DATA_W-1:0] pack_status
    (
        input logic sel,
        input logic vpp
    );
        logic [DATA_W-1:0] word;
        word = '0;
        word[FSPMC_SELECT_BIT] = sel;
        word[FSPMC_VOLTAGE_BIT] = vpp;
        return word;
    endfunction

    // ==============================================
    // decode
    logic sel_bit;
    logic hit;
    logic lanes_ok;
    logic byte_write;
    logic next_sel;
    logic [DATA_W-1:0] next_rdata;

    // register address match
    assign hit = cpu_addr == FSPMC_ADDR;
    // narrower accesses are dropped without any indication
    assign lanes_ok = lanes_full(cpu_byte_en);
    // a write lands only as a whole byte at this address
    assign byte_write = cpu_wr && hit && lanes_ok;

    // only the select field takes written data; every other
    // bit, the voltage flag among them, ignores the bus
    assign next_sel = byte_write
        ? cpu_wdata[FSPMC_SELECT_BIT]
        : sel_bit;

    // readback: select as it will stand, pin as sampled now
    assign next_rdata = pack_status(next_sel,
        prog_voltage_present);

    // ==============================================
    // state
    // select field, the only bit holding written state
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            sel_bit <= FSPMC_RESET_VALUE[FSPMC_SELECT_BIT];
        else
            sel_bit <= next_sel;
    end

    // ==============================================
    // outputs
    // readback byte, registered so the cpu never sees the
    // pin mid-change; during reset it shows the reset byte
    // with the flag set, then the live pin from the next edge
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            cpu_rdata <= FSPMC_RESET_VALUE;
        else
            cpu_rdata <= next_rdata;
    end

    // mode select toward the flash controller
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            self_program_select <= FSPMC_RESET_VALUE[FSPMC_SELECT_BIT];
        else
            self_program_select <= next_sel;
    end

    // ==============================================
    // checks
    // a partial-lane write must leave the select alone
    property p_byte_only;
        @(posedge core_clk) disable iff (!arst_n)
        (cpu_wr && hit && !lanes_ok) |=> $stable(sel_bit);
    endproperty
    a_byte_only: assert property (p_byte_only)
        else $error("partial byte write changed select");

    // with no accepted write the mode select holds
    property p_idle_hold;
        @(posedge core_clk) disable iff (!arst_n)
        !byte_write |=> $stable(self_program_select);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("select changed without a whole-byte write");

    // a write to another address is ignored
    property p_wrong_addr;
        @(posedge core_clk) disable iff (!arst_n)
        (cpu_wr && !hit) |=> $stable(self_program_select);
    endproperty
    a_wrong_addr: assert property (p_wrong_addr)
        else $error("write to another address changed select");

    // an accepted write sets the mode from the select data bit
    property p_select_write;
        @(posedge core_clk) disable iff (!arst_n)
        byte_write |=>
            self_program_select == $past(cpu_wdata[FSPMC_SELECT_BIT]);
    endproperty
    a_select_write: assert property (p_select_write)
        else $error("select bit did not take written value");

    // the writable bits of the data show in the readback one edge later
    property p_write_masked;
        @(posedge core_clk) disable iff (!arst_n)
        byte_write |=> (cpu_rdata & FSPMC_WRITE_MASK)
            == ($past(cpu_wdata) & FSPMC_WRITE_MASK);
    endproperty
    a_write_masked: assert property (p_write_masked)
        else $error("readback does not show the written select");

    // voltage flag follows the pin one edge later
    property p_voltage_live;
        @(posedge core_clk) disable iff (!arst_n)
        1'b1 |=> cpu_rdata[FSPMC_VOLTAGE_BIT]
            == $past(prog_voltage_present);
    endproperty
    a_voltage_live: assert property (p_voltage_live)
        else $error("voltage flag does not follow pin");

    // data opposite to the pin must not reach the flag
    property p_write_keeps_vpp;
        @(posedge core_clk) disable iff (!arst_n)
        (byte_write
            && cpu_wdata[FSPMC_VOLTAGE_BIT] != prog_voltage_present)
            |=> cpu_rdata[FSPMC_VOLTAGE_BIT]
                == $past(prog_voltage_present);
    endproperty
    a_write_keeps_vpp: assert property (p_write_keeps_vpp)
        else $error("write altered voltage flag");

    // unused readback bits read zero, select bit mirrors mode
    property p_rdata_layout;
        @(posedge core_clk) disable iff (!arst_n)
        1'b1 |-> cpu_rdata == pack_status(self_program_select,
            cpu_rdata[FSPMC_VOLTAGE_BIT]);
    endproperty
    a_rdata_layout: assert property (p_rdata_layout)
        else $error("readback layout broken");

    // during reset the register shows its reset byte
    property p_reset_value;
        @(posedge core_clk)
        !arst_n |-> cpu_rdata == FSPMC_RESET_VALUE
            && self_program_select
                == FSPMC_RESET_VALUE[FSPMC_SELECT_BIT];
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("reset value not 08h");
endmodule
`default_nettype wire

// >>> design/fspmc_pkg.sv
// package for the flash self-program mode control register
// assumes a byte-wide cpu register port, one clock, async active-low reset
package fspmc_pkg;
    // ==============================================
    // register layout
    localparam int unsigned FSPMC_DATA_W = 8;
    localparam logic [7:0] FSPMC_RESET_VALUE = 8'h08;
    localparam int unsigned FSPMC_SELECT_BIT = 0;
    localparam int unsigned FSPMC_VOLTAGE_BIT = 3;
    // bits that hold written state (select only)
    localparam logic [7:0] FSPMC_WRITE_MASK = 8'h01;
    // chip select address of the register, arbitrary default
    localparam logic [7:0] FSPMC_ADDR = 8'h00;
endpackage

// >>> verif/testbench.sv
// self-checking bench for the self-program mode control register
// assumes the design carries its own assertions
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import fspmc_pkg::*;
    logic core_clk, arst_n, cpu_wr, pin, sel_o, sel;
    logic [7:0] addr, be, wd, rd;
    logic [8:0] q[$];
    int failures = 0, n_checks = 0, seed;
    fspmc_ctrl fspmc_ctrl_i (.core_clk(core_clk), .arst_n(arst_n),
        .cpu_addr(addr), .cpu_wr(cpu_wr), .cpu_byte_en(be),
        .cpu_wdata(wd), .cpu_rdata(rd), .prog_voltage_present(pin),
        .self_program_select(sel_o));
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // drive one cycle, note the expected byte and select
    task automatic step(input logic w, input logic [7:0] a, b, d,
        input logic p);
        {cpu_wr, addr, be, wd, pin} <= {w, a, b, d, p};
        if (w && a == FSPMC_ADDR && b == 8'hff)
            sel = d[0];
        @(posedge core_clk);
        q.push_back({4'h0, p, 2'h0, sel, sel});
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // result watcher, one note per cycle
    always @(negedge core_clk)
        if (q.size() > 0)
            chk({rd, sel_o}, q.pop_front());
    initial
    begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    initial
    begin
        #20000 failures++;
        wrap_up;
    end
    // ==========================================
    // reset, directed writes, then random traffic
    initial
    begin
        seed = 32'h6278d49e;
        sel = 0;
        {cpu_wr, addr, be, wd, pin} = '0;
        arst_n = 1;
        // a real falling edge at 1 ns, clear of start-up ordering
        #1 arst_n = 0;
        #2 chk({rd, sel_o}, 9'h010);
        repeat (2) @(posedge core_clk);
        // release between edges, so no edge sees it change
        @(negedge core_clk) arst_n = 1;
        @(posedge core_clk);
        step(1, FSPMC_ADDR, 8'hff, 8'hf7, 1); // data bit3 low, pin high
        step(1, FSPMC_ADDR, 8'hfe, 8'h00, 0); // partial byte refused
        step(1, 8'h01, 8'hff, 8'h00, 1); // other address refused
        step(1, FSPMC_ADDR, 8'hff, 8'hf8, 0); // data bit3 high, pin low
        // mid-run reset with the select on: it must drop back
        step(1, FSPMC_ADDR, 8'hff, 8'h01, 1);
        @(negedge core_clk);
        #2 arst_n = 0;
        #1 chk({rd, sel_o}, 9'h010);
        sel = 0;
        @(posedge core_clk);
        step(0, FSPMC_ADDR, 8'hff, 8'h01, 1); // in reset: reads 08h
        @(negedge core_clk) arst_n = 1;
        @(posedge core_clk);
        repeat (60)
            step(1'($random(seed)), ($random(seed) & 1) ? FSPMC_ADDR :
                8'($random(seed)), ($random(seed) & 1) ? 8'hff :
                8'($random(seed)), 8'($random(seed)), 1'($random(seed)));
        // let the watcher take the last note before the verdict
        repeat (2) @(negedge core_clk);
        wrap_up;
    end
endmodule
`default_nettype wire
